/* design/error_capture_map.svh */
/*
  bit positions, register offsets and reset values for the error capture
  status word. assumes inclusion by bare name from design files.
*/
`ifndef ERROR_CAPTURE_MAP_SVH
`define ERROR_CAPTURE_MAP_SVH

// status word bit positions
`define ECS_BIT_SECDED_FLAG 3
`define ECS_BIT_CTRL_PE_FLAG 5
`define ECS_BIT_MAINS_FAIL 36
`define ECS_BIT_SHUTDOWN 37
`define ECS_BIT_SYNDROME_LO 40
`define ECS_BIT_ADDR_LO 48
`define ECS_BIT_PE_PORT_LO 54
`define ECS_BIT_BKPT_PORT_LO 56
`define ECS_BIT_BKPT_FUNC_LO 58
`define ECS_BIT_BKPT_FLAG 77

// apb byte offsets of the register window
`define ECS_OFF_WORD0 12'h000
`define ECS_OFF_WORD1 12'h004
`define ECS_OFF_WORD2 12'h008
`define ECS_OFF_FLAGS 12'h00c
`define ECS_OFF_CTRL 12'h010

// flags register bit layout (write one to clear the locking flags)
`define ECS_FLG_SECDED 0
`define ECS_FLG_CTRL_PE 1
`define ECS_FLG_BKPT 2

// reset values
`define ECS_CTRL_RESET 32'h0000_0000
`define ECS_FLAGS_RESET 3'h0

`endif

/* design/error_capture_pkg.sv */
/*
  types for the error capture status word.
  assumes the map header supplies bit positions and offsets; field widths are written here.
*/
package error_capture_pkg;

  // one captured correction-code error context
  typedef struct packed {
    logic [7:0] syndrome;
    logic [5:0] addr;
  } secded_cap_t;

  // one captured breakpoint context
  typedef struct packed {
    logic [1:0] func;
    logic [1:0] port;
  } bkpt_cap_t;

  // error event inputs from the memory side
  typedef struct packed {
    logic secded_err;
    logic [7:0] syndrome;
    logic [17:0] fail_addr;
    logic ctrl_pe;
    logic [1:0] pe_port;
    logic bkpt_match;
    logic [1:0] bkpt_port;
    logic [1:0] bkpt_func;
  } err_event_t;

endpackage : error_capture_pkg

/* design/capture_field.sv */
/*
  one frozen capture field: loads on an event while its locking flag is
  clear, then holds until the flag is cleared from the register side.
  assumes events and clear arrive on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module capture_field #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // event side
  input wire logic event_in,
  input wire logic [WIDTH-1:0] data_in,
  // software side
  input wire logic clear,
  output logic locked,
  output logic [WIDTH-1:0] data_out
);

  typedef struct packed {
    logic lock;
    logic [WIDTH-1:0] data;
  } state_t;

  state_t st_reg;
  state_t st_next;

  initial begin
    if (WIDTH < 1) $error("capture_field width must be positive");
  end

  // a new event wins over a clear in the same cycle so the flag is never lost
  always_comb begin
    st_next = st_reg;
    if (clear) st_next.lock = 1'b0;
    if (event_in && !st_reg.lock) begin
      st_next.lock = 1'b1;
      st_next.data = data_in;
    end else if (event_in && clear) begin
      st_next.lock = 1'b1; // set wins; data stays frozen from the first event
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign locked = st_reg.lock;
  assign data_out = st_reg.data;

  AST_FROZEN: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_reg.lock |=> data_out == $past(data_out))
    else $error("locked capture field changed");
  AST_LOAD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (event_in && !st_reg.lock) |=> (locked && data_out == $past(data_in)))
    else $error("capture did not load on event");

endmodule : capture_field
`default_nettype wire

/* design/error_capture_status_word.sv */
/*
  error capture part of the maintenance status word: power warnings,
  correction-code syndrome and failing address, controller parity port,
  breakpoint port and function. apb slave, 32-bit data, zero wait.
  assumes event inputs are on pclk and environment pins are asynchronous.
*/
// Local design decisions: the APB interface to the registers and the address map.
// Notes on behaviour
// - bits 36,37 power warnings; 38,39 unused
// - correction error loads syndrome and address bits
// - bit 52 holds address 16, or 17 large
// - controller parity port code loads on flag
// - breakpoint match loads port and function codes
// - capture bits 40-59 are read only
`timescale 1ns/1ns
`default_nettype none
`include "error_capture_map.svh"
module error_capture_status_word #(
  parameter bit LARGE_MODEL = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // environment pins
  input wire logic mains_fail_pin,
  input wire logic shutdown_pin,
  // memory events
  input wire error_capture_pkg::err_event_t events,
  // word to the maintenance display
  output logic [95:0] status_word
);

  typedef struct packed {
    logic [1:0] env_meta;
    logic [1:0] env_sync;
    logic [31:0] rdata;
    logic slverr;
    logic [31:0] ctrl;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [2:0] lock;
  logic [2:0] clr;
  logic [13:0] secded_data;
  error_capture_pkg::secded_cap_t secded_q;
  logic [1:0] pe_port_q;
  error_capture_pkg::bkpt_cap_t bkpt_q;
  logic [5:0] addr_sel;
  logic access;
  logic [95:0] word;

  // address field: bits 48-50 addr 0-2, then 15/16/17 or 16/17/3
  always_comb begin
    addr_sel[2:0] = events.fail_addr[2:0];
    if (LARGE_MODEL) begin
      addr_sel[3] = events.fail_addr[16];
      addr_sel[4] = events.fail_addr[17];
      addr_sel[5] = events.fail_addr[3];
    end else begin
      addr_sel[3] = events.fail_addr[15];
      addr_sel[4] = events.fail_addr[16];
      addr_sel[5] = events.fail_addr[17];
    end
  end
  assign secded_data = {events.syndrome, addr_sel};

  function automatic logic is_reg(input logic [11:0] a,
                                  input logic [11:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  assign access = psel && penable;
  // write one to the flags register clears the matching locking flag
  assign clr = (access && pwrite && is_reg(paddr, `ECS_OFF_FLAGS)
                && pstrb[0]) ? pwdata[2:0] : 3'h0;

  capture_field #(.WIDTH(14)) u_secded (
    .pclk(pclk), .presetn(presetn),
    .event_in(events.secded_err), .data_in(secded_data),
    .clear(clr[`ECS_FLG_SECDED]), .locked(lock[`ECS_FLG_SECDED]),
    .data_out(secded_q)
  );
  capture_field #(.WIDTH(2)) u_pe (
    .pclk(pclk), .presetn(presetn),
    .event_in(events.ctrl_pe), .data_in(events.pe_port),
    .clear(clr[`ECS_FLG_CTRL_PE]), .locked(lock[`ECS_FLG_CTRL_PE]),
    .data_out(pe_port_q)
  );
  capture_field #(.WIDTH(4)) u_bkpt (
    .pclk(pclk), .presetn(presetn),
    .event_in(events.bkpt_match),
    .data_in({events.bkpt_func, events.bkpt_port}),
    .clear(clr[`ECS_FLG_BKPT]), .locked(lock[`ECS_FLG_BKPT]),
    .data_out(bkpt_q)
  );

  // assemble the status word; neighbouring bits stay zero here
  always_comb begin
    word = '0;
    word[`ECS_BIT_SECDED_FLAG] = lock[`ECS_FLG_SECDED];
    word[`ECS_BIT_CTRL_PE_FLAG] = lock[`ECS_FLG_CTRL_PE];
    word[`ECS_BIT_BKPT_FLAG] = lock[`ECS_FLG_BKPT];
    word[`ECS_BIT_MAINS_FAIL] = st_reg.env_sync[0];
    word[`ECS_BIT_SHUTDOWN] = st_reg.env_sync[1];
    word[`ECS_BIT_SYNDROME_LO +: 8] = secded_q.syndrome;
    word[`ECS_BIT_ADDR_LO +: 6] = secded_q.addr;
    word[`ECS_BIT_PE_PORT_LO +: 2] = pe_port_q;
    word[`ECS_BIT_BKPT_PORT_LO +: 2] = bkpt_q.port;
    word[`ECS_BIT_BKPT_FUNC_LO +: 2] = bkpt_q.func;
  end

  // apb reads and the control scratch register; status words ignore
  // writes so capture bits can never be forced by software
  always_comb begin
    st_next = st_reg;
    st_next.env_meta = {shutdown_pin, mains_fail_pin};
    st_next.env_sync = st_reg.env_meta;
    if (psel && !penable) begin
      st_next.slverr = 1'b0;
      st_next.rdata = 32'h0000_0000;
      unique case (paddr)
        `ECS_OFF_WORD0: st_next.rdata = word[31:0];
        `ECS_OFF_WORD1: st_next.rdata = word[63:32];
        `ECS_OFF_WORD2: st_next.rdata = word[95:64];
        `ECS_OFF_FLAGS: st_next.rdata = {29'h0, lock};
        `ECS_OFF_CTRL: st_next.rdata = st_reg.ctrl;
        default: st_next.slverr = 1'b1;
      endcase
      if (pwrite && (is_reg(paddr, `ECS_OFF_WORD0)
          || is_reg(paddr, `ECS_OFF_WORD1)
          || is_reg(paddr, `ECS_OFF_WORD2))) begin
        st_next.slverr = 1'b1;
      end
    end
    if (access && pwrite && is_reg(paddr, `ECS_OFF_CTRL)) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) st_next.ctrl[i*8 +: 8] = pwdata[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.ctrl <= `ECS_CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = st_reg.rdata;
  assign pslverr = access && st_reg.slverr;
  assign status_word = word;

  // a pin sampled at one edge reaches the word two edges later
  AST_POWER_SYNC: assert property (
    @(posedge pclk) disable iff (!presetn)
    status_word[`ECS_BIT_MAINS_FAIL] == $past(mains_fail_pin, 2))
    else $error("mains fail bit not two stages behind pin");
  AST_SHUT_SYNC: assert property (
    @(posedge pclk) disable iff (!presetn)
    status_word[`ECS_BIT_SHUTDOWN] == $past(shutdown_pin, 2))
    else $error("shutdown bit not two stages behind pin");
  AST_UNUSED_BITS: assert property (
    @(posedge pclk) disable iff (!presetn)
    status_word[39:38] == 2'b00)
    else $error("unused bits 38-39 not zero");
  AST_SECDED_LOAD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (events.secded_err && !lock[0]) |=>
      status_word[47:40] == $past(events.syndrome))
    else $error("syndrome not captured");
  AST_ADDR51: assert property (
    @(posedge pclk) disable iff (!presetn)
    (events.secded_err && !lock[0]) |=> status_word[51] ==
      (LARGE_MODEL ? $past(events.fail_addr[16])
                   : $past(events.fail_addr[15])))
    else $error("bit 51 holds the wrong address bit");
  AST_ADDR52: assert property (
    @(posedge pclk) disable iff (!presetn)
    (events.secded_err && !lock[0]) |=> status_word[52] ==
      (LARGE_MODEL ? $past(events.fail_addr[17])
                   : $past(events.fail_addr[16])))
    else $error("bit 52 holds the wrong address bit");
  AST_PE_LOAD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (events.ctrl_pe && !lock[1]) |=>
      (status_word[55:54] == $past(events.pe_port) && status_word[5]))
    else $error("parity port code not captured");
  AST_BKPT_LOAD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (events.bkpt_match && !lock[2]) |=>
      (status_word[59:56] == $past({events.bkpt_func, events.bkpt_port})
       && status_word[77]))
    else $error("breakpoint codes not captured");
  // the error flag was latched in setup, so the access must show it
  AST_RO_ERR: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && (paddr == `ECS_OFF_WORD0
     || paddr == `ECS_OFF_WORD1 || paddr == `ECS_OFF_WORD2)) |-> pslverr)
    else $error("write to a status word not refused");
  AST_READ_ONLY: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == `ECS_OFF_WORD1 && !events.secded_err
     && !events.ctrl_pe && !events.bkpt_match && clr == 3'h0) |=>
      status_word[59:40] == $past(status_word[59:40]))
    else $error("write changed capture bits");
  AST_HOLD_LOCK: assert property (
    @(posedge pclk) disable iff (!presetn)
    (lock[0] && !clr[0]) |=> (lock[0] &&
      status_word[53:40] == $past(status_word[53:40])))
    else $error("locked syndrome reloaded");
  // a clear with no new error in the same cycle must unlock the field
  AST_CLEAR: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clr[0] && !events.secded_err) |=> !status_word[`ECS_BIT_SECDED_FLAG])
    else $error("locking flag not cleared by software");

endmodule : error_capture_status_word
`default_nettype wire

/* bench/mem_event_model.sv */
/*
  memory side model: fires one-cycle correction, parity and breakpoint
  events. assumes the bench calls fire from the pclk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module mem_event_model (
  // clock
  input wire logic pclk,
  // events to the status word
  output var error_capture_pkg::err_event_t events
);
  error_capture_pkg::err_event_t e;
  initial events = '0;
  // one strobe per call; data goes inverted after so stale values never match
  task fire(input logic [2:0] k, input logic [7:0] s, input logic [17:0] a,
            input logic [3:0] pf);
    e = '0;
    e.secded_err = k[0];
    e.ctrl_pe = k[1];
    e.bkpt_match = k[2];
    e.syndrome = s;
    e.fail_addr = a;
    e.pe_port = pf[1:0];
    e.bkpt_port = pf[1:0];
    e.bkpt_func = pf[3:2];
    @(posedge pclk);
    events <= e;
    @(posedge pclk);
    e = ~e;
    e.secded_err = 1'b0;
    e.ctrl_pe = 1'b0;
    e.bkpt_match = 1'b0;
    events <= e;
  endtask : fire
endmodule : mem_event_model
`default_nettype wire

/* bench/error_capture_status_word_bench.sv */
/*
  self-checking bench for the error capture status word.
  builds a small-model and a large-model instance on one apb bus; the
  apb task waits for pready rather than assuming a fixed latency.
*/
`timescale 1ns/1ns
`default_nettype none
module error_capture_status_word_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mains_fail_pin = 1'b0;
  logic shutdown_pin = 1'b0;
  error_capture_pkg::err_event_t events;
  logic [95:0] status_word;
  logic [95:0] status_word_lg;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int n_checks = 0;
  always #4 pclk = ~pclk;
  error_capture_status_word u_error_capture_status_word (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mains_fail_pin(mains_fail_pin),
    .shutdown_pin(shutdown_pin), .events(events),
    .status_word(status_word));
  // second instance covers the largest model's address packing
  error_capture_status_word #(.LARGE_MODEL(1'b1))
    u_error_capture_status_word_large (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
    .mains_fail_pin(mains_fail_pin), .shutdown_pin(shutdown_pin),
    .events(events), .status_word(status_word_lg));
  mem_event_model u_mem_event_model (.pclk(pclk), .events(events));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk
  // one apb transfer; holds everything until pready is seen high, then
  // returns at the falling edge so the write's effect has settled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb
  task ev(input logic [2:0] k, input logic [7:0] s, input logic [17:0] a,
          input logic [3:0] pf);
    u_mem_event_model.fire(k, s, a, pf);
    @(negedge pclk);
  endtask : ev
  // pins change just after a rising edge and show two edges later
  task t_pins;
    @(posedge pclk);
    mains_fail_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("mains", 32'h1, status_word[39:36]);
    @(posedge pclk);
    mains_fail_pin <= 1'b0;
    shutdown_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("shutdown", 32'h2, status_word[39:36]);
    @(posedge pclk);
    shutdown_pin <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : t_pins
  // address bits 0,2,3,16,17 set: small packs 17,16,15,2,1,0 and large
  // packs 3,17,16,2,1,0; the flag bit sits just above the 14 bits
  task t_secded;
    ev(3'h1, 8'ha5, 18'h3000d, 4'h0);
    chk("secded", 32'h75a5, {status_word[3], status_word[53:40]});
    chk("sec lg", 32'h7da5, {status_word_lg[3], status_word_lg[53:40]});
    apb(1'b0, 12'h004, 32'h0);
    chk("word1", 32'h35a5, rd[21:8]);
    ev(3'h1, 8'h3c, 18'h0ffff, 4'h0);
    chk("locked", 32'h35a5, status_word[53:40]);
    chk("locked lg", 32'h3da5, status_word_lg[53:40]);
    apb(1'b0, 12'h00c, 32'h0);
    chk("flags", 32'h1, rd[2:0]);
    apb(1'b1, 12'h00c, 32'h1);
    chk("cleared", 32'h0, status_word[3]);
    ev(3'h1, 8'h3c, 18'h08002, 4'h0);
    chk("reload", 32'h4a3c, {status_word[3], status_word[53:40]});
    chk("rel lg", 32'h423c, {status_word_lg[3], status_word_lg[53:40]});
  endtask : t_secded
  task t_pe_bkpt;
    ev(3'h2, 8'h0, 18'h0, 4'h2);
    chk("pe", 32'h6, {status_word[5], status_word[55:54]});
    ev(3'h2, 8'h0, 18'h0, 4'h1);
    chk("pe lock", 32'h2, status_word[55:54]);
    ev(3'h4, 8'h0, 18'h0, 4'hd);
    chk("bkpt", 32'h1d, {status_word[77], status_word[59:56]});
  endtask : t_pe_bkpt
  task t_ro;
    apb(1'b1, 12'h004, 32'hffff_ffff);
    chk("ro err", 32'h1, er);
    chk("ro data", 32'hd_8a3c, status_word[59:40]);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 12'h010, 32'h5a5a_0f0f);
    apb(1'b0, 12'h010, 32'h0);
    chk("ctrl", 32'h5a5a_0f0f, rd);
  endtask : t_ro
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("reset lo", 32'h0, status_word[31:0]);
    chk("reset hi", 32'h0, status_word[95:64]);
    apb(1'b0, 12'h010, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    t_pins();
    t_secded();
    t_pe_bkpt();
    t_ro();
    end_sim();
  end
  // watchdog well past the few dozen cycles the tests need
  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    end_sim();
  end
endmodule : error_capture_status_word_bench
`default_nettype wire
